// ===== common/timer01_pkg.sv
// Constants and types for the dual legacy counter/timer.
// Assumes a byte-wide special-function register port from the CPU.
// Function
// - Timer zero mode 3 splits it into two 8-bit counters.
// - Split low byte uses timer zero run, select, gate and flag.
// - Split high byte times only, runs on timer one run, sets its flag.
// - In split, timer one counts no pins and sets no flag.
// - Timer one overflow still leaves as a strobe for baud and conversions.
// - In split, timer one runs in modes 0 to 2, stops in 3.
// - Overflow sets flag; software or vector acknowledge clears it.
// - Run bits enable each timer, except timer one in split, which runs without its run bit.
// - External flags set by edge or level; vector clears edge only.
// - In level mode, external flag reads as inverse of the low-active pin.
// - Type bit: 0 active-low level, 1 falling edge.
// - Gate bit makes run also need the interrupt pin high.
// - Count select: 0 timer clock, 1 falling edges on count pin.
// - Mode field: 13-bit, 16-bit, 8-bit reload, inactive or split.
// - Clock select: 0 prescaled, 1 system; ignored when counting pins.
// - Prescale: divide by 12, 4, 48, or external clock by 8.
// - External clock is synchronised before counting.
// - Timer one high byte is bits 15 to 8, read and write.
// - Mode 0 counts 13 bits, flag on wrap to zero.
// - Mode 2 reloads low byte from high byte on overflow.
package timer01_pkg;
  localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_ZERO_LO = 8'h8a;
  localparam logic [7:0] ADDR_ONE_LO = 8'h8b;
  localparam logic [7:0] ADDR_ZERO_HI = 8'h8c;
  localparam logic [7:0] ADDR_ONE_HI = 8'h8d;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h8e;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CLK_SEL_MASK = 8'h1b;
  localparam int B_TF1 = 7;
  localparam int B_TR1 = 6;
  localparam int B_TF0 = 5;
  localparam int B_TR0 = 4;
  localparam int B_IE1 = 3;
  localparam int B_IT1 = 2;
  localparam int B_IE0 = 1;
  localparam int B_IT0 = 0;
  localparam int B_TIMER_ONE_GATE_ENABLE = 7;
  localparam int B_CSEL1 = 6;
  localparam int B_TIMER_ZERO_GATE_ENABLE = 3;
  localparam int B_CSEL0 = 2;
  localparam int B_SYS1 = 4;
  localparam int B_SYS0 = 3;
  localparam int ACK_TF1 = 3;
  localparam int ACK_TF0 = 2;
  localparam int ACK_IE1 = 1;
  localparam int ACK_IE0 = 0;
  localparam logic [5:0] DIV_BY12 = 6'd12;
  localparam logic [5:0] DIV_BY4 = 6'd4;
  localparam logic [5:0] DIV_BY48 = 6'd48;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage

// ===== src/dual_counter_timer.sv
// Two legacy counter/timers with shared control, mode and clock select.
// Pins are synchronous to clk; vector acknowledges come from the
// interrupt controller as one-cycle pulses.
`timescale 1ns/100ps
module dual_counter_timer
  import timer01_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire sfr_req_t sfr,
  input wire logic [3:0] vec_ack,
  input wire logic ext_irq_zero_pin_n,
  input wire logic ext_irq_one_pin_n,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic ext_osc_clk_in,
  output logic [7:0] rdata_q,
  output logic [3:0] irq_req_q,
  output logic t1_ovf_strobe_q
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] timer_run_and_flag_control_q, timer_run_and_flag_control_d;
  logic [7:0] timer_mode_select_q, timer_mode_select_d;
  logic [7:0] timer_clock_select_q, timer_clock_select_d;
  logic [7:0] timer_zero_low_count_q, timer_zero_low_count_d;
  logic [7:0] timer_zero_high_count_q, timer_zero_high_count_d;
  logic [7:0] timer_one_low_count_q, timer_one_low_count_d;
  logic [7:0] timer_one_high_count_q, timer_one_high_count_d;
  logic [5:0] pre_cnt_q, pre_cnt_d;
  logic [2:0] osc_div_q, osc_div_d;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [3:0] pin_q, pin_qq;
  logic [7:0] rdata_d;
  logic [5:0] div;
  logic pre_tick, osc_rise, split;
  logic run0, run1, inc0, inc1, inc_hi0;
  logic set0, set1, ovf1;
  logic [3:0] fall;
  logic [16:0] r0, r1;
  logic [7:0] ctl, mds, cks;

  assign ctl = timer_run_and_flag_control_q;
  assign mds = timer_mode_select_q;
  assign cks = timer_clock_select_q;

  // One step of a count byte pair; bit 16 is the overflow
  function automatic logic [16:0] step(input logic [1:0] m,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    case (m)
      MODE_13BIT: step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16BIT: step = s16;
      MODE_RELOAD8: step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default: step = {s8[8], hi, s8[7:0]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling: pin_q order is ext_irq_one_pin_n, ext_irq_zero_pin_n, count1, count0
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= 4'hf;
      pin_qq <= 4'hf;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      pin_q <= {ext_irq_one_pin_n, ext_irq_zero_pin_n,
                timer_one_count_pin, timer_zero_count_pin};
      pin_qq <= pin_q;
      osc_s1_q <= ext_osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Pin edges are only seen if each level lasts one clock
  assign fall = pin_qq & ~pin_q;
  assign osc_rise = osc_s2_q & ~osc_s3_q;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    timer_run_and_flag_control_d = timer_run_and_flag_control_q;
    timer_mode_select_d = timer_mode_select_q;
    timer_clock_select_d = timer_clock_select_q;
    timer_zero_low_count_d = timer_zero_low_count_q;
    timer_zero_high_count_d = timer_zero_high_count_q;
    timer_one_low_count_d = timer_one_low_count_q;
    timer_one_high_count_d = timer_one_high_count_q;
    pre_cnt_d = pre_cnt_q;
    osc_div_d = osc_div_q;
    rdata_d = rdata_q;
    pre_tick = 1'b0;

    // Shared prescaler
    case (cks[1:0])
      2'b00: div = DIV_BY12;
      2'b01: div = DIV_BY4;
      2'b10: div = DIV_BY48;
      default: div = DIV_BY12;
    endcase
    if (cks[1:0] == 2'b11) begin
      if (osc_rise) begin
        osc_div_d = osc_div_q + 3'd1;
        pre_tick = (osc_div_q == EXT_DIV_LAST);
      end
    end else begin
      // >= keeps a mid-count divider change from running away
      pre_tick = (pre_cnt_q >= div - 6'd1);
      pre_cnt_d = pre_tick ? 6'd0 : pre_cnt_q + 6'd1;
    end

    // Enables and count sources
    split = (mds[1:0] == MODE_SPLIT);
    run0 = ctl[B_TR0] & (~mds[B_TIMER_ZERO_GATE_ENABLE] | pin_q[2]);
    inc0 = run0 & (mds[B_CSEL0] ? fall[0]
                                : (cks[B_SYS0] | pre_tick));
    run1 = ctl[B_TR1] & (~mds[B_TIMER_ONE_GATE_ENABLE] | pin_q[3]);
    if (split) begin
      // Mode field alone runs timer one; pin counting is cut off
      inc1 = (mds[5:4] != MODE_SPLIT) & (cks[B_SYS1] | pre_tick);
    end else begin
      inc1 = run1 & (mds[5:4] != MODE_SPLIT)
             & (mds[B_CSEL1] ? fall[1] : (cks[B_SYS1] | pre_tick));
    end
    // Split high byte uses timer zero clock select as its source
    inc_hi0 = split & ctl[B_TR1] & (cks[B_SYS0] | pre_tick);

    r0 = step(mds[1:0], timer_zero_high_count_q, timer_zero_low_count_q);
    r1 = step(mds[5:4], timer_one_high_count_q, timer_one_low_count_q);
    if (inc0) begin
      timer_zero_low_count_d = r0[7:0];
      if (!split)
        timer_zero_high_count_d = r0[15:8];
    end
    if (inc_hi0)
      timer_zero_high_count_d = timer_zero_high_count_q + 8'h01;
    if (inc1) begin
      timer_one_low_count_d = r1[7:0];
      timer_one_high_count_d = r1[15:8];
    end
    set0 = inc0 & r0[16];
    ovf1 = inc1 & r1[16];
    set1 = split ? (inc_hi0 & (&timer_zero_high_count_q)) : ovf1;

    // Vector acknowledges
    if (vec_ack[ACK_TF1])
      timer_run_and_flag_control_d[B_TF1] = 1'b0;
    if (vec_ack[ACK_TF0])
      timer_run_and_flag_control_d[B_TF0] = 1'b0;
    if (vec_ack[ACK_IE1] && ctl[B_IT1])
      timer_run_and_flag_control_d[B_IE1] = 1'b0;
    if (vec_ack[ACK_IE0] && ctl[B_IT0])
      timer_run_and_flag_control_d[B_IE0] = 1'b0;

    // Software writes beat increments
    if (sfr.wr) begin
      case (sfr.addr)
        ADDR_RUN_FLAG: timer_run_and_flag_control_d = sfr.wdata;
        ADDR_MODE: timer_mode_select_d = sfr.wdata;
        ADDR_CLK_SEL: timer_clock_select_d = sfr.wdata & CLK_SEL_MASK;
        ADDR_ZERO_LO: timer_zero_low_count_d = sfr.wdata;
        ADDR_ZERO_HI: timer_zero_high_count_d = sfr.wdata;
        ADDR_ONE_LO: timer_one_low_count_d = sfr.wdata;
        ADDR_ONE_HI: timer_one_high_count_d = sfr.wdata;
        default: ;
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    if (set0)
      timer_run_and_flag_control_d[B_TF0] = 1'b1;
    if (set1)
      timer_run_and_flag_control_d[B_TF1] = 1'b1;
    if (ctl[B_IT0]) begin
      if (fall[2])
        timer_run_and_flag_control_d[B_IE0] = 1'b1;
    end else begin
      timer_run_and_flag_control_d[B_IE0] = ~pin_q[2];
    end
    if (ctl[B_IT1]) begin
      if (fall[3])
        timer_run_and_flag_control_d[B_IE1] = 1'b1;
    end else begin
      timer_run_and_flag_control_d[B_IE1] = ~pin_q[3];
    end

    // Read path; unmapped addresses answer zero
    if (sfr.rd) begin
      case (sfr.addr)
        ADDR_RUN_FLAG: rdata_d = ctl;
        ADDR_MODE: rdata_d = mds;
        ADDR_CLK_SEL: rdata_d = cks & CLK_SEL_MASK;
        ADDR_ZERO_LO: rdata_d = timer_zero_low_count_q;
        ADDR_ZERO_HI: rdata_d = timer_zero_high_count_q;
        ADDR_ONE_LO: rdata_d = timer_one_low_count_q;
        ADDR_ONE_HI: rdata_d = timer_one_high_count_q;
        default: rdata_d = RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_run_and_flag_control_q <= RST_BYTE;
      timer_mode_select_q <= RST_BYTE;
      timer_clock_select_q <= RST_BYTE;
      timer_zero_low_count_q <= RST_BYTE;
      timer_zero_high_count_q <= RST_BYTE;
      timer_one_low_count_q <= RST_BYTE;
      timer_one_high_count_q <= RST_BYTE;
      pre_cnt_q <= 6'd0;
      osc_div_q <= 3'd0;
      rdata_q <= RST_BYTE;
      irq_req_q <= 4'h0;
      t1_ovf_strobe_q <= 1'b0;
    end else begin
      timer_run_and_flag_control_q <= timer_run_and_flag_control_d;
      timer_mode_select_q <= timer_mode_select_d;
      timer_clock_select_q <= timer_clock_select_d;
      timer_zero_low_count_q <= timer_zero_low_count_d;
      timer_zero_high_count_q <= timer_zero_high_count_d;
      timer_one_low_count_q <= timer_one_low_count_d;
      timer_one_high_count_q <= timer_one_high_count_d;
      pre_cnt_q <= pre_cnt_d;
      osc_div_q <= osc_div_d;
      rdata_q <= rdata_d;
      irq_req_q <= {timer_run_and_flag_control_d[B_TF1],
                    timer_run_and_flag_control_d[B_TF0],
                    timer_run_and_flag_control_d[B_IE1],
                    timer_run_and_flag_control_d[B_IE0]};
      t1_ovf_strobe_q <= ovf1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_ovf0_flag;
    @(posedge clk) disable iff (srst)
    set0 |=> ctl[B_TF0] && irq_req_q[ACK_TF0];
  endproperty
  a_ovf0_flag: assert property (p_ovf0_flag)
    else $error("overflow did not set timer zero flag");

  property p_reload;
    @(posedge clk) disable iff (srst)
    (inc0 && mds[1:0] == MODE_RELOAD8 && timer_zero_low_count_q == 8'hff
     && !sfr.wr)
    |=> timer_zero_low_count_q == $past(timer_zero_high_count_q)
        && $stable(timer_zero_high_count_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload from high byte failed");

  property p_strobe16;
    @(posedge clk) disable iff (srst)
    (inc1 && mds[5:4] == MODE_16BIT && timer_one_low_count_q == 8'hff
     && timer_one_high_count_q == 8'hff && !sfr.wr)
    |=> t1_ovf_strobe_q ##1 !t1_ovf_strobe_q;
  endproperty
  a_strobe16: assert property (p_strobe16)
    else $error("timer one strobe wrong");

  property p_run_off;
    @(posedge clk) disable iff (srst)
    (!ctl[B_TR0] && !sfr.wr) |=> $stable(timer_zero_low_count_q);
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("timer zero counted while stopped");

  property p_gate;
    @(posedge clk) disable iff (srst)
    (mds[B_TIMER_ZERO_GATE_ENABLE] && !pin_q[2] && !sfr.wr)
    |=> $stable(timer_zero_low_count_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated timer counted with pin low");

  property p_split_stop;
    @(posedge clk) disable iff (srst)
    (split && mds[5:4] == MODE_SPLIT && !sfr.wr)
    |=> $stable(timer_one_low_count_q) && !t1_ovf_strobe_q;
  endproperty
  a_split_stop: assert property (p_split_stop)
    else $error("timer one ran in mode 3");

  property p_level_irq;
    @(posedge clk) disable iff (srst)
    (!ctl[B_IT0] && !sfr.wr) ##1 !ctl[B_IT0]
    |-> ctl[B_IE0] == !$past(pin_q[2]);
  endproperty
  a_level_irq: assert property (p_level_irq)
    else $error("level flag not inverse of pin");

  property p_unused;
    @(posedge clk) disable iff (srst)
    sfr.rd && sfr.addr == ADDR_CLK_SEL |=> (rdata_q & ~CLK_SEL_MASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused clock select bits not zero");

  property p_prescale12;
    @(posedge clk) disable iff (srst)
    (pre_tick && cks[1:0] == 2'b00 && !sfr.wr)
    |=> (!pre_tick || cks[1:0] != 2'b00) [*8];
  endproperty
  a_prescale12: assert property (p_prescale12)
    else $error("prescale tick too early");

  property p_write_wins;
    @(posedge clk) disable iff (srst)
    sfr.wr && sfr.addr == ADDR_ZERO_LO
    |=> timer_zero_low_count_q == $past(sfr.wdata);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("count write lost");

  c_split_hi: cover property (@(posedge clk) disable iff (srst) set1 && split);
  c_edge_irq: cover property (@(posedge clk) disable iff (srst)
    ctl[B_IT1] && fall[3]);
  c_ext_tick: cover property (@(posedge clk) disable iff (srst)
    pre_tick && cks[1:0] == 2'b11);
endmodule

// ===== verif/dual_legacy_counter_timer_tb.sv
// Self-checking bench for the dual counter/timer.
// Assumes the pin model drives every pin; registers only via sfr.
`timescale 1ns/100ps
module dual_legacy_counter_timer_tb;
  import timer01_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  sfr_req_t sfr = '0;
  logic [3:0] vec_ack = 4'h0;
  logic cnt0, cnt1, irq0_n, irq1_n, osc;
  logic [7:0] rdata_q;
  logic [3:0] irq_req_q;
  logic t1_ovf_strobe_q;
  logic [7:0] lfsr = 8'h47;
  logic [7:0] d;
  int num_errors = 0;
  int n_checks = 0;
  int n_strobe = 0;
  int divs[3] = '{12, 4, 48};
  int c;

  always #10 clk = ~clk;
  // Strobe stands from one rising edge to the next; count it mid-cycle
  always @(negedge clk) if (t1_ovf_strobe_q) n_strobe++;

  pin_source_model pins (.clk(clk), .cnt0(cnt0), .cnt1(cnt1),
    .irq0_n(irq0_n), .irq1_n(irq1_n), .osc(osc));
  dual_counter_timer dual_counter_timer_i (.clk(clk), .srst(srst),
    .sfr(sfr), .vec_ack(vec_ack), .ext_irq_zero_pin_n(irq0_n),
    .ext_irq_one_pin_n(irq1_n), .timer_zero_count_pin(cnt0),
    .timer_one_count_pin(cnt1), .ext_osc_clk_in(osc),
    .rdata_q(rdata_q), .irq_req_q(irq_req_q),
    .t1_ovf_strobe_q(t1_ovf_strobe_q));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr.addr = a;
    sfr.wdata = v;
    sfr.wr = 1'b1;
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    sfr.addr = a;
    sfr.rd = 1'b1;
    @(negedge clk);
    sfr.rd = 1'b0;
    v = rdata_q;
  endtask

  task automatic ack(input int b);
    @(negedge clk);
    vec_ack[b] = 1'b1;
    @(negedge clk);
    vec_ack = 4'h0;
    @(negedge clk);
  endtask

  // Reference count step; v holds {high, low}
  function automatic int step(input int m, input int v, inout int ovf);
    int hi, lo, k;
    hi = v >> 8;
    lo = v & 255;
    case (m)
      0: begin
        k = (((hi << 5) | (lo & 31)) + 1) & 8191;
        lo = (lo & 224) | (k & 31);
        hi = k >> 5;
        ovf += (k == 0);
      end
      1: begin
        k = (v + 1) & 65535;
        ovf += (k == 0);
        hi = k >> 8;
        lo = k & 255;
      end
      2: begin
        if (lo == 255) begin
          lo = hi;
          ovf++;
        end else
          lo++;
      end
      default: begin
        lo = (lo + 1) & 255;
        ovf += (lo == 0);
      end
    endcase
    return (hi << 8) | lo;
  endfunction

  task automatic count_run(input int t, input int m, input int v,
                           input int n);
    int e, ovf;
    logic [7:0] lo, hi;
    ovf = 0;
    e = v;
    wr(ADDR_RUN_FLAG, 8'h00);
    wr(t ? ADDR_ONE_LO : ADDR_ZERO_LO, 8'(v));
    wr(t ? ADDR_ONE_HI : ADDR_ZERO_HI, 8'(v >> 8));
    wr(ADDR_MODE, t ? (8'h40 | 8'(m << 4)) : (8'h04 | 8'(m)));
    n_strobe = 0;
    wr(ADDR_RUN_FLAG, t ? 8'h40 : 8'h10);
    pins.pulse(t, n);
    for (int i = 0; i < n; i++) e = step(m, e, ovf);
    // Flags first: the stop write below rewrites the whole control byte
    chk("overflow flag", 8'(ovf > 0), 8'(irq_req_q[t ? 3 : 2]));
    chk("strobes", 8'(t == 1 ? ovf : 0), 8'(n_strobe));
    ack(t ? 3 : 2);
    chk("flag after ack", 8'h00, 8'(irq_req_q[t ? 3 : 2]));
    wr(ADDR_RUN_FLAG, 8'h00);
    rd(t ? ADDR_ONE_LO : ADDR_ZERO_LO, lo);
    rd(t ? ADDR_ONE_HI : ADDR_ZERO_HI, hi);
    chk("count low", 8'(e), lo);
    chk("count high", 8'(e >> 8), hi);
    $display("test count t%0d m%0d done", t, m);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rd(ADDR_RUN_FLAG, d);
    chk("control reset", RST_BYTE, d);
    rd(ADDR_MODE, d);
    chk("mode reset", RST_BYTE, d);
    rd(ADDR_CLK_SEL, d);
    chk("clock select reset", RST_BYTE, d);
    rd(8'h90, d);
    chk("unmapped read", 8'h00, d);
    wr(ADDR_CLK_SEL, 8'hff);
    rd(ADDR_CLK_SEL, d);
    chk("clock select mask", 8'h1b, d);
    wr(ADDR_ONE_HI, 8'ha5);
    rd(ADDR_ONE_HI, d);
    chk("timer one high", 8'ha5, d);
    wr(ADDR_CLK_SEL, 8'h00);
    $display("test registers done");
    count_run(0, 0, 'hfffe, 3);
    count_run(1, 0, 'hfffe, 2);
    count_run(0, 1, 'hfffe, 3);
    count_run(1, 1, 'h00ff, 2);
    count_run(1, 2, 'h80fe, 3);
    count_run(0, 3, 'h00ff, 2);
    // Run bit off, then gate held by a low pin, then gate open
    wr(ADDR_ZERO_LO, 8'h00);
    wr(ADDR_MODE, 8'h0d);
    pins.pulse(0, 2);
    rd(ADDR_ZERO_LO, d);
    chk("run off", 8'h00, d);
    pins.set_irq(0, 1'b0);
    wr(ADDR_RUN_FLAG, 8'h10);
    pins.pulse(0, 2);
    rd(ADDR_ZERO_LO, d);
    chk("gated", 8'h00, d);
    pins.set_irq(0, 1'b1);
    pins.pulse(0, 2);
    rd(ADDR_ZERO_LO, d);
    chk("gate open", 8'h02, d);
    $display("test gate done");
    // Edge mode on input zero, level mode on input one
    wr(ADDR_RUN_FLAG, 8'h01);
    pins.set_irq(0, 1'b0);
    repeat (4) @(negedge clk);
    chk("edge flag", 8'h01, 8'(irq_req_q[0]));
    ack(0);
    chk("edge ack", 8'h00, 8'(irq_req_q[0]));
    pins.set_irq(0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      pins.set_irq(1, lfsr[0]);
      ack(1);
      repeat (2) @(negedge clk);
      chk("level flag", 8'(!lfsr[0]), 8'(irq_req_q[1]));
    end
    pins.set_irq(1, 1'b1);
    // Edge mode on input one, cleared by its vector acknowledge
    wr(ADDR_RUN_FLAG, 8'h04);
    pins.set_irq(1, 1'b0);
    repeat (4) @(negedge clk);
    chk("edge flag one", 8'h01, 8'(irq_req_q[1]));
    ack(1);
    chk("edge ack one", 8'h00, 8'(irq_req_q[1]));
    pins.set_irq(1, 1'b1);
    $display("test external interrupts done");
    // Prescale codes, counting a fixed span in mode 1
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_ZERO_LO, 8'h00);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CLK_SEL, 8'(s));
      wr(ADDR_RUN_FLAG, 8'h10);
      repeat (480) @(negedge clk);
      wr(ADDR_RUN_FLAG, 8'h00);
      rd(ADDR_ZERO_LO, d);
      c = (s == 3) ? (480 * 20 / 70) / 8 : 480 / divs[s];
      chk("prescale near", 8'h01, 8'(d + 2 >= c && d <= c + 2));
    end
    $display("test prescale done");
    // Split: timer one strobes without its flag, stops in mode 3
    wr(ADDR_CLK_SEL, 8'h10);
    wr(ADDR_ONE_LO, 8'hfe);
    wr(ADDR_ONE_HI, 8'hfe);
    wr(ADDR_MODE, 8'h23);
    n_strobe = 0;
    repeat (20) @(negedge clk);
    chk("split strobes", 8'h01, 8'(n_strobe > 0));
    chk("split no flag", 8'h00, 8'(irq_req_q[3]));
    wr(ADDR_MODE, 8'h33);
    // A strobe launched with the old mode may still stand here
    @(negedge clk);
    n_strobe = 0;
    repeat (20) @(negedge clk);
    chk("split stopped", 8'h00, 8'(n_strobe));
    wr(ADDR_ZERO_HI, 8'hff);
    wr(ADDR_CLK_SEL, 8'h18);
    wr(ADDR_RUN_FLAG, 8'h40);
    repeat (6) @(negedge clk);
    chk("high byte flag", 8'h01, 8'(irq_req_q[3]));
    $display("test split done");
    give_verdict();
  end
endmodule

// ===== verif/pin_source_model.sv
// Far-side pins: count inputs, interrupt pins and a free oscillator.
// Pins change on the falling clock edge; the oscillator is unrelated.
`timescale 1ns/100ps
module pin_source_model (
  input wire logic clk,
  output logic cnt0,
  output logic cnt1,
  output logic irq0_n,
  output logic irq1_n,
  output logic osc
);
  initial begin
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    irq0_n = 1'b1;
    irq1_n = 1'b1;
    osc = 1'b0;
  end

  // Free-running crystal, phase unrelated to clk
  always #35 osc = ~osc;

  ////////////////////////////////////////////////////////////////////////
  task automatic pulse(input int t, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (t == 1)
        cnt1 = 1'b0;
      else
        cnt0 = 1'b0;
      // Three cycles per level leaves margin over the sampler
      repeat (3) @(negedge clk);
      if (t == 1)
        cnt1 = 1'b1;
      else
        cnt0 = 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask

  task automatic set_irq(input int w, input logic v);
    @(negedge clk);
    if (w == 1)
      irq1_n = v;
    else
      irq0_n = v;
  endtask
endmodule
